// ===== rtl/lcd_instruction_executor.sv
`timescale 1ns/1ns
`default_nettype none
`include "lcd_exec_map.svh"
module lcd_instruction_executor import lcd_exec_pkg::*; #(
  parameter int FLASH_DIV = `FLASH_DIV_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_strobe,
  input wire host_req_s i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_operation_pending_flag,
  output logic [6:0] o_address_pointer,
  output logic o_glyph_sel,
  output mode_s o_mode,
  output logic [6:0] o_display_shift,
  output logic o_flash_phase,
  output logic [3:0] o_cursor_row,
  output logic [5:0] o_glyph_addr,
  output logic [7:0] o_glyph_wdata,
  output logic o_glyph_we,
  input wire logic [7:0] i_glyph_rdata
);
  //////////////////////////////////////////////////////////////////////
  exec_state_e state_reg;
  mode_s mode_reg;
  logic [6:0] ptr_reg;
  logic glyph_reg;
  logic [6:0] shift_reg;
  logic nib_hi_reg;
  logic [3:0] nib_buf_reg;
  logic [6:0] ptr_stepped;
  logic [6:0] acc_ptr;
  logic [7:0] wait_reg;
  logic [6:0] clr_addr_reg;
  logic step_pend_reg;
  logic step_dir_reg;
  logic [31:0] flash_cnt_reg;
  logic flash_reg;
  logic [7:0] out_reg;
  logic rvalid_reg;
  logic busy;
  logic full_code;
  logic [7:0] code;
  logic take;
  logic [7:0] tram_rdata;
  logic tram_we;
  logic [6:0] tram_addr;
  logic [7:0] tram_wdata;
  logic [6:0] shift_max;

  assign busy = (state_reg != ST_IDLE);
  assign o_operation_pending_flag = busy;
  assign o_address_pointer = ptr_reg;
  assign o_glyph_sel = glyph_reg;
  assign o_mode = mode_reg;
  assign o_display_shift = shift_reg;
  assign o_flash_phase = flash_reg & mode_reg.flash_on;
  assign o_cursor_row = mode_reg.font_tall ? 4'hb : 4'h8;
  assign o_rdata = out_reg;
  assign o_rvalid = rvalid_reg;
  assign shift_max = mode_reg.two_line ? `SHIFT_MAX_2LINE : `SHIFT_MAX_1LINE;

  //////////////////////////////////////////////////////////////////////
  // Nibble assembly: upper half first in 4-bit mode
  assign full_code = mode_reg.bus8 | ~nib_hi_reg;
  assign code = mode_reg.bus8 ? i_req.data : {nib_buf_reg, i_req.data[7:4]};
  assign take = i_strobe & ~i_req.rd_nwr & full_code & ~busy;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      nib_hi_reg <= 1'b1;
      nib_buf_reg <= 4'h0;
    end else if (i_strobe && !mode_reg.bus8) begin
      // A refused write still flips the phase so host and block stay paired
      nib_hi_reg <= ~nib_hi_reg;
      if (nib_hi_reg) begin
        nib_buf_reg <= i_req.data[7:4];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read path: status or latched RAM byte, halves in 4-bit mode
  logic [7:0] rd_word;
  // RAM bytes come straight from the ports, so a read after an address load is valid
  assign rd_word = i_req.reg_sel ? (glyph_reg ? i_glyph_rdata : tram_rdata)
                                 : {busy, ptr_reg};
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      out_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= i_strobe & i_req.rd_nwr;
      if (i_strobe && i_req.rd_nwr) begin
        if (mode_reg.bus8 || nib_hi_reg) begin
          out_reg <= rd_word;
        end else begin
          out_reg <= {rd_word[3:0], 4'h0};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pointer seen by the RAM ports: already stepped while an update is due,
  // so an access taken inside the update delay lands on the right cell
  assign ptr_stepped = next_ptr(ptr_reg, step_dir_reg, glyph_reg, mode_reg.two_line);
  assign acc_ptr = step_pend_reg ? ptr_stepped : ptr_reg;

  //////////////////////////////////////////////////////////////////////
  // Command execution
  logic data_rd_take;
  assign data_rd_take = i_strobe & i_req.rd_nwr & i_req.reg_sel & full_code & ~busy;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      mode_reg <= '{step_up: 1'b1, bus8: 1'b1, default: 1'b0};
      ptr_reg <= 7'h00;
      glyph_reg <= 1'b0;
      shift_reg <= 7'h00;
      wait_reg <= 8'h00;
      clr_addr_reg <= 7'h00;
      step_pend_reg <= 1'b0;
      step_dir_reg <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take || data_rd_take) begin
            state_reg <= ST_BUSY;
            wait_reg <= 8'(`OP_CLOCKS);
            step_pend_reg <= 1'b0;
            // A step still due is applied first; address loads below override it
            if (step_pend_reg) begin
              ptr_reg <= ptr_stepped;
            end
            if (i_req.reg_sel) begin
              step_pend_reg <= 1'b1;
              step_dir_reg <= mode_reg.step_up;
              if (!data_rd_take && !glyph_reg && mode_reg.auto_scroll) begin
                if (mode_reg.step_up) begin
                  shift_reg <= (shift_reg == shift_max) ? 7'h00 : shift_reg + 7'h01;
                end else begin
                  shift_reg <= (shift_reg == 7'h00) ? shift_max : shift_reg - 7'h01;
                end
              end
            end else if (code[7]) begin
              ptr_reg <= code[6:0];
              glyph_reg <= 1'b0;
            end else if (code[6]) begin
              ptr_reg <= {1'b0, code[5:0]};
              glyph_reg <= 1'b1;
            end else if (code[5]) begin
              mode_reg.bus8 <= code[4];
              mode_reg.two_line <= code[3];
              mode_reg.font_tall <= code[2] & ~code[3];
              if (code[3] && shift_reg > `SHIFT_MAX_2LINE) begin
                shift_reg <= 7'h00;
              end
            end else if (code[4]) begin
              if (!code[3]) begin
                step_pend_reg <= 1'b1;
                step_dir_reg <= code[2];
              end else if (code[2]) begin
                shift_reg <= (shift_reg == 7'h00) ? shift_max : shift_reg - 7'h01;
              end else begin
                shift_reg <= (shift_reg == shift_max) ? 7'h00 : shift_reg + 7'h01;
              end
            end else if (code[3]) begin
              mode_reg.screen_on <= code[2];
              mode_reg.cursor_on <= code[1];
              mode_reg.flash_on <= code[0];
            end else if (code[2]) begin
              mode_reg.step_up <= code[1];
              mode_reg.auto_scroll <= code[0];
            end else if (code[1]) begin
              ptr_reg <= 7'h00;
              glyph_reg <= 1'b0;
              shift_reg <= 7'h00;
              wait_reg <= 8'(`CLEAR_CLOCKS);
            end else if (code[0]) begin
              state_reg <= ST_CLEAR;
              clr_addr_reg <= 7'h00;
              ptr_reg <= 7'h00;
              glyph_reg <= 1'b0;
              shift_reg <= 7'h00;
              mode_reg.step_up <= 1'b1;
            end
          end
        end
        ST_CLEAR: begin
          // One text cell is filled with a space on every clock
          clr_addr_reg <= clr_addr_reg + 7'h01;
          if (clr_addr_reg == 7'h7f) begin
            state_reg <= ST_BUSY;
            wait_reg <= 8'(`OP_CLOCKS);
          end
        end
        ST_BUSY: begin
          // Leaving busy arms the update delay for a pending pointer step
          if (wait_reg <= 8'h01) begin
            state_reg <= ST_IDLE;
            wait_reg <= 8'(`ADDR_UPDATE_CLOCKS);
          end else begin
            wait_reg <= wait_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // Pointer moves a short delay after the flag clears
      if (state_reg == ST_IDLE && step_pend_reg && !(take || data_rd_take)) begin
        if (wait_reg <= 8'h01) begin
          step_pend_reg <= 1'b0;
          ptr_reg <= next_ptr(ptr_reg, step_dir_reg, glyph_reg, mode_reg.two_line);
        end else begin
          wait_reg <= wait_reg - 8'h01;
        end
      end
    end
  end

  // Pointer wrap: glyph RAM is 64 bytes, text RAM follows the line layout
  function automatic logic [6:0] next_ptr(input logic [6:0] p, input logic up,
                                          input logic gl, input logic two);
    logic [6:0] r;
    r = up ? p + 7'h01 : p - 7'h01;
    if (gl) begin
      r = {1'b0, r[5:0]};
    end else if (two) begin
      if (up && p == `LINE1_LAST) r = `LINE2_FIRST;
      else if (up && p == `LINE2_LAST) r = 7'h00;
      else if (!up && p == `LINE2_FIRST) r = `LINE1_LAST;
      else if (!up && p == 7'h00) r = `LINE2_LAST;
    end else begin
      if (up && p == `TEXT_LAST_1LINE) r = 7'h00;
      else if (!up && p == 7'h00) r = `TEXT_LAST_1LINE;
    end
    return r;
  endfunction : next_ptr

  //////////////////////////////////////////////////////////////////////
  // Text RAM port and glyph RAM strobes
  assign tram_we = (state_reg == ST_CLEAR) | (take & i_req.reg_sel & ~glyph_reg);
  assign tram_addr = (state_reg == ST_CLEAR) ? clr_addr_reg : acc_ptr;
  assign tram_wdata = (state_reg == ST_CLEAR) ? `SPACE_CODE : code;
  assign o_glyph_we = take & i_req.reg_sel & glyph_reg;
  assign o_glyph_addr = acc_ptr[5:0];
  assign o_glyph_wdata = code;

  text_ram u_text_ram (
    .i_clk(i_clk),
    .i_we(tram_we),
    .i_addr(tram_addr),
    .i_wdata(tram_wdata),
    .o_rdata(tram_rdata)
  );

  //////////////////////////////////////////////////////////////////////
  // Flash phase timer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      flash_cnt_reg <= 32'h0;
      flash_reg <= 1'b0;
    end else if (flash_cnt_reg >= 32'(FLASH_DIV - 1)) begin
      flash_cnt_reg <= 32'h0;
      flash_reg <= ~flash_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + 32'h1;
    end
  end
endmodule : lcd_instruction_executor
`default_nettype wire

// ===== rtl/lcd_exec_map.svh
`ifndef LCD_EXEC_MAP_SVH
`define LCD_EXEC_MAP_SVH
`define SPACE_CODE 8'h20
`define TEXT_RAM_WORDS 128
`define TEXT_LAST_1LINE 7'h4f
`define LINE1_LAST 7'h27
`define LINE2_FIRST 7'h40
`define LINE2_LAST 7'h67
`define SHIFT_MAX_1LINE 7'h4f
`define SHIFT_MAX_2LINE 7'h27
`define OP_CLOCKS 31
`define CLEAR_CLOCKS 128
`define ADDR_UPDATE_CLOCKS 4
`define CLK_HZ 25000000
`define FLASH_MS 320
`define FLASH_DIV_DEFAULT 8000000
`endif

// ===== rtl/lcd_exec_pkg.sv
package lcd_exec_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_BUSY = 4'b0010,
    ST_CLEAR = 4'b0100,
    ST_STEP = 4'b1000
  } exec_state_e;
  typedef struct packed {
    logic step_up;
    logic auto_scroll;
    logic screen_on;
    logic cursor_on;
    logic flash_on;
    logic bus8;
    logic two_line;
    logic font_tall;
  } mode_s;
  typedef struct packed {
    logic reg_sel;
    logic rd_nwr;
    logic [7:0] data;
  } host_req_s;
endpackage : lcd_exec_pkg

// ===== rtl/text_ram.sv
`timescale 1ns/1ns
`default_nettype none
module text_ram (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:127];
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule : text_ram
`default_nettype wire

// ===== test/lcd_exec_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module lcd_exec_checker import lcd_exec_pkg::*; #(
  parameter int FLASH_DIV = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_strobe,
  input wire host_req_s i_req,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_operation_pending_flag,
  input wire logic [6:0] o_address_pointer,
  input wire logic o_glyph_sel,
  input wire mode_s o_mode,
  input wire logic [6:0] o_display_shift,
  input wire logic o_flash_phase,
  input wire logic [3:0] o_cursor_row
);
  localparam int FLASH_WIN = 2 * FLASH_DIV + 2;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic wr_take;
  logic rd_stat;
  assign wr_take = i_strobe && !i_req.rd_nwr && !o_operation_pending_flag && o_mode.bus8;
  assign rd_stat = i_strobe && i_req.rd_nwr && !i_req.reg_sel && o_mode.bus8;
  pend_on_take_a: assert property (wr_take |=> o_operation_pending_flag)
    else $error("pending flag did not rise after a taken write");
  pend_hold_a: assert property ($rose(o_operation_pending_flag) |-> o_operation_pending_flag [*8])
    else $error("pending flag dropped too early");
  status_word_a: assert property (rd_stat |=>
    o_rdata == {$past(o_operation_pending_flag), $past(o_address_pointer)})
    else $error("status byte does not hold flag and pointer");
  read_answer_a: assert property (i_strobe && i_req.rd_nwr |=> o_rvalid)
    else $error("read strobe got no valid pulse");
  busy_refuse_a: assert property (o_operation_pending_flag && i_strobe && !i_req.rd_nwr
    && !i_req.reg_sel |=> $stable(o_mode))
    else $error("command taken while pending");
  cursor_row_a: assert property ($stable(o_mode) |->
    o_cursor_row == (o_mode.font_tall ? 4'hb : 4'h8))
    else $error("cursor row does not match font");
  glyph_no_shift_a: assert property (o_glyph_sel && i_strobe && i_req.reg_sel
    && !o_operation_pending_flag |=> $stable(o_display_shift) [*8])
    else $error("glyph access shifted the display");
  flash_toggle_a: assert property (o_mode.flash_on |-> ##[0:FLASH_WIN]
    ($changed(o_flash_phase) || !o_mode.flash_on))
    else $error("flash phase stuck");
endmodule : lcd_exec_checker
bind lcd_instruction_executor lcd_exec_checker #(.FLASH_DIV(FLASH_DIV)) lcd_exec_checker_inst (
  .i_clk, .i_nrst, .i_strobe, .i_req, .o_rdata, .o_rvalid, .o_operation_pending_flag,
  .o_address_pointer, .o_glyph_sel, .o_mode, .o_display_shift, .o_flash_phase, .o_cursor_row);
`default_nettype wire

// ===== test/host_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_bus_model import lcd_exec_pkg::*; (
  input wire logic i_clk,
  input wire logic i_pend,
  output logic o_strobe,
  output host_req_s o_req
);
  initial begin
    o_strobe = 1'b0;
    o_req = '0;
  end
  // One code as one strobe, or two nibble strobes when nib is set
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, input logic nib,
                      input logic poll);
    int n;
    n = 0;
    while (poll && i_pend !== 1'b0 && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    @(negedge i_clk);
    o_req = {rs, rw, d};
    o_strobe = 1'b1;
    @(negedge i_clk);
    if (nib) begin
      o_req.data = {d[3:0], ~d[3:0]};
      @(negedge i_clk);
    end
    o_strobe = 1'b0;
    o_req.data = ~o_req.data;
  endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// ===== test/tb_lcd_instruction_executor.sv
`timescale 1ns/1ns
`default_nettype none
module tb_lcd_instruction_executor import lcd_exec_pkg::*;;
  logic clk, nrst, strobe, rvalid, pend, gsel, fphase, gwe;
  host_req_s req;
  logic [7:0] rdata, gwdata, grdata, d;
  logic [6:0] ptr, shift;
  mode_s mode, mm;
  logic [3:0] crow;
  logic [5:0] gaddr;
  logic [7:0] gmem [64];
  logic [7:0] tram [128];
  int mptr, mshift, mg, cyc, err_count, n_checks, a, prev;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (gwe) gmem[gaddr] <= gwdata;
  assign grdata = gmem[gaddr];
  host_bus_model host_bus_model_inst (.i_clk(clk), .i_pend(pend), .o_strobe(strobe), .o_req(req));
  lcd_instruction_executor #(.FLASH_DIV(8)) lcd_instruction_executor_inst (
    .i_clk(clk), .i_nrst(nrst), .i_strobe(strobe), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_operation_pending_flag(pend), .o_address_pointer(ptr),
    .o_glyph_sel(gsel), .o_mode(mode), .o_display_shift(shift), .o_flash_phase(fphase),
    .o_cursor_row(crow), .o_glyph_addr(gaddr), .o_glyph_wdata(gwdata), .o_glyph_we(gwe),
    .i_glyph_rdata(grdata));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  function automatic int nxt(int p, bit inc);
    int r;
    r = (p + (inc ? 1 : -1)) & 'h7f;
    if (mg != 0) return r & 'h3f;
    if (mm.two_line) begin
      if (inc && p == 'h27) return 'h40;
      if (inc && p == 'h67) return 0;
      if (!inc && p == 'h40) return 'h27;
      if (!inc && p == 0) return 'h67;
      return r;
    end
    if (inc && p == 'h4f) return 0;
    if (!inc && p == 0) return 'h4f;
    return r;
  endfunction : nxt
  task automatic settle();
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    while (pend !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    repeat (6) @(negedge clk);
    chk("pending", 8'h00, {7'h0, pend});
    chk("pointer", 8'(mptr), {1'b0, ptr});
    chk("shift", 8'(mshift), {1'b0, shift});
    chk("mode", mm, mode);
    chk("glyph select", 8'(mg), {7'h0, gsel});
  endtask : settle
  task automatic cmd(input logic [7:0] c);
    host_bus_model_inst.xfer(1'b0, 1'b0, c, !mm.bus8, 1'b1);
    if (c[7]) {mg, mptr} = {32'd0, 25'd0, c[6:0]};
    else if (c[6]) {mg, mptr} = {32'd1, 26'd0, c[5:0]};
    else if (c[5]) {mm.bus8, mm.two_line, mm.font_tall} = {c[4], c[3], c[2] & ~c[3]};
    else if (c[4] && c[3]) mshift = (mshift + (c[2] ? -1 : 1) + 80) % (mm.two_line ? 40 : 80);
    else if (c[4]) mptr = nxt(mptr, c[2]);
    else if (c[3]) {mm.screen_on, mm.cursor_on, mm.flash_on} = c[2:0];
    else if (c[2]) {mm.step_up, mm.auto_scroll} = c[1:0];
    else if (c[1] || c[0]) {mptr, mshift, mg} = '0;
    if (c == 8'h01) mm.step_up = 1'b1;
    if (c == 8'h01) foreach (tram[i]) tram[i] = 8'h20;
    settle();
  endtask : cmd
  task automatic put(input logic [7:0] v);
    host_bus_model_inst.xfer(1'b1, 1'b0, v, !mm.bus8, 1'b1);
    if (mg == 0) tram[mptr] = v;
    if (mg == 0 && mm.auto_scroll)
      mshift = (mshift + (mm.step_up ? 1 : -1) + 80) % (mm.two_line ? 40 : 80);
    mptr = nxt(mptr, mm.step_up);
  endtask : put
  task automatic rd(input logic [7:0] e);
    host_bus_model_inst.xfer(1'b1, 1'b1, 8'h00, 1'b0, 1'b1);
    chk("read valid", 8'h01, {7'h0, rvalid});
    mptr = nxt(mptr, mm.step_up);
    settle();
    chk("read data", e, rdata);
  endtask : rd
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    {nrst, cyc, err_count, n_checks, mptr, mshift, mg} = '0;
    mm = 8'h84;
    void'($urandom(36));
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    cmd(8'h34);
    chk("cursor row", 8'hb, {4'h0, crow});
    cmd(8'h38);
    chk("cursor row", 8'h8, {4'h0, crow});
    cmd(8'h30);
    cmd(8'h0f);
    cmd(8'h90);
    for (int e = 3; e >= 0; e--) begin
      cmd(8'h04 | 8'(e));
      put(8'($urandom));
      settle();
    end
    for (int s = 0; s < 4; s++) cmd(8'h10 | 8'(s << 2));
    $display("test entry and shift done");
    a = $urandom_range(0, 79);
    d = 8'($urandom);
    cmd(8'h07);
    cmd(8'h80 | 8'(a));
    put(d);
    settle();
    cmd(8'h80 | 8'(a));
    rd(d);
    cmd(8'h40 | 8'(a[5:0]));
    put(~d);
    settle();
    cmd(8'h40 | 8'(a[5:0]));
    rd(gmem[a[5:0]]);
    chk("glyph byte", ~d, gmem[a[5:0]]);
    cmd(8'h02);
    cmd(8'h80 | 8'(a));
    rd(d);
    $display("test readback done");
    prev = mptr;
    put(8'h41);
    host_bus_model_inst.xfer(1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
    chk("status", {1'b1, 7'(prev)}, rdata);
    host_bus_model_inst.xfer(1'b0, 1'b0, 8'h08, 1'b0, 1'b0);
    settle();
    cmd(8'h08);
    cmd(8'h01);
    cmd(8'h80 | 8'(a));
    rd(8'h20);
    $display("test busy and clear done");
    cmd(8'h38);
    cmd(8'ha7);
    put(8'h5a);
    settle();
    cmd(8'h20);
    cmd(8'h85);
    put(d);
    settle();
    cmd(8'h30);
    cmd(8'h85);
    rd(d);
    $display("test two-line and nibble done");
    close_out();
  end
endmodule : tb_lcd_instruction_executor
`default_nettype wire
